/* inc/mfp_regs.svh */
// Register indices, field positions, reset values and function codes
// of the multifunction pin map. Assumes byte address = 4 x index.
`ifndef MFP_REGS_SVH
`define MFP_REGS_SVH

`define MFP_IDX_W          16
`define MFP_IDX_UPDATE     16'h000F
`define MFP_IDX_COMB_LO    16'h0100
`define MFP_IDX_COMB_HI    16'h0101
`define MFP_IDX_FUNC_FIRST 16'h0102
`define MFP_IDX_FUNC_LAST  16'h0108
`define MFP_IDX_PIN_STATE  16'h0110

`define MFP_UPDATE_BIT     0
`define MFP_FUNC_OE_BIT    7
`define MFP_CODE_MSB       6
`define MFP_STATE_CTL_LSB  16
`define MFP_STATE_LATCH    31

`define MFP_FUNC_RST       8'h00
`define MFP_COMB_RST       8'h00

`define MFP_CTL_NOOP       7'h00
`define MFP_CTL_UPDATE     7'h01
`define MFP_CTL_PWRDN      7'h02
`define MFP_CTL_WDOG_CLR   7'h03
`define MFP_CTL_SYNC_ALL   7'h04
`define MFP_CTL_CLR_ALL    7'h10
`define MFP_CTL_CLR_COMMON 7'h11
`define MFP_CTL_CLR_LOOP0  7'h12
`define MFP_CTL_CLR_LOOP1  7'h13

`define MFP_ST_ZERO        7'h00
`define MFP_ST_ONE         7'h01
`define MFP_ST_CORE_CLK    7'h02
`define MFP_ST_WDOG        7'h03
`define MFP_ST_CAL_BUSY    7'h04
`define MFP_ST_SYS_LOCK    7'h05
`define MFP_ST_SYS_STABLE  7'h06
`define MFP_ST_BOTH_LOCK   7'h07
`define MFP_ST_LOOP0_LOCK  7'h08
`define MFP_ST_LOOP1_LOCK  7'h09
`define MFP_ST_NV_SAVE     7'h0A
`define MFP_ST_NV_LOAD     7'h0B
`define MFP_ST_NV_FAULT    7'h0C
`define MFP_ST_TEMP        7'h0D
`define MFP_ST_IRQ_ALL     7'h10
`define MFP_ST_IRQ_COMMON  7'h11
`define MFP_ST_IRQ_LOOP0   7'h12
`define MFP_ST_IRQ_LOOP1   7'h13

`define MFP_MODE_AND       2'b00
`define MFP_MODE_NAND      2'b01
`define MFP_MODE_OR        2'b10
`define MFP_MODE_NOR       2'b11

`endif

/* inc/mfp_pkg.sv */
// Types shared by the multifunction pin map.
// Constants other than MFP_NUM_CTL live in mfp_regs.svh.
package mfp_pkg;
  typedef logic [6:0] mfp_code_t;
  typedef logic [1:0] mfp_mode_t;
  typedef logic [7:0] mfp_func_t;
  localparam int MFP_NUM_CTL = 8;
endpackage

/* hw/mfp_pin_map.sv */
// Multifunction pin map: per-pin function select, control combining,
// status drive, classic Wishbone slave with 32-bit data.
// Pin levels pass a two-stage synchroniser on sys_clk; wire level built outside.
//
// Overview of operation
// - Output enable clear makes pin a control
// - Low seven function bits select the function
// - Several control pins may share one function
// - Two-bit combining code per control pin
// - Same field selects driver mode for status
// - Code 00: true level into AND
// - Code 01: inverted level into AND
// - Code 10: true level into OR
// - Code 11: inverted level into OR
// - OR group first, then AND all terms
// - Single pin: 00/10 true, 01/11 inverted
// - Control 0x01 drives the update strobe
// - Control 0x10-0x13 clear interrupt event groups
// - Status 0x10-0x13 show interrupt group ORs
// - Status 0x04-0x06 show system clock flags
// - Status 0x07-0x09 show loop lock flags
// - Status 0x0A-0x0C show nonvolatile flags
// - Status 0x0D shows temperature alarm
// - Output enable set makes pin a status
// - New functions apply only after update
`timescale 1ns/1ps
`default_nettype none
`include "mfp_regs.svh"

module mfp_pin_map
  import mfp_pkg::*;
#(
  parameter int NUM_PINS = 7,
  parameter int ADR_W    = 18
) (
  input  wire logic                sys_clk,
  input  wire logic                rst_b,
  input  wire logic                clk_en,
  input  wire logic                wb_cyc_i,
  input  wire logic                wb_stb_i,
  input  wire logic                wb_we_i,
  input  wire logic [3:0]          wb_sel_i,
  input  wire logic [ADR_W-1:0]    wb_adr_i,
  input  wire logic [31:0]         wb_dat_i,
  output logic      [31:0]         wb_dat_o,
  output logic                     wb_ack_o,
  input  wire logic [NUM_PINS-1:0] pin_in,
  output logic      [NUM_PINS-1:0] pin_out,
  output logic      [NUM_PINS-1:0] pin_oe_b,
  input  wire logic                system_reference_clock_cal_busy,
  input  wire logic                system_reference_clock_locked,
  input  wire logic                system_reference_clock_stable,
  input  wire logic                loop0_locked,
  input  wire logic                loop1_locked,
  input  wire logic                nv_save_busy,
  input  wire logic                nv_load_busy,
  input  wire logic [1:0]          nv_fault,
  input  wire logic                temp_alarm,
  input  wire logic                wdog_timeout,
  input  wire logic                irq_any,
  input  wire logic                irq_common,
  input  wire logic                irq_loop0,
  input  wire logic                irq_loop1,
  output logic                     io_update_o,
  output logic                     power_down_o,
  output logic                     wdog_clear_o,
  output logic                     sync_all_o,
  output logic      [3:0]          irq_clear_o
);

  localparam int IW = `MFP_IDX_W;

  // Control functions in output order; NOOP has no slot
  localparam mfp_code_t CTL_CODES [MFP_NUM_CTL] = '{
    `MFP_CTL_UPDATE, `MFP_CTL_PWRDN, `MFP_CTL_WDOG_CLR,
    `MFP_CTL_SYNC_ALL, `MFP_CTL_CLR_ALL, `MFP_CTL_CLR_COMMON,
    `MFP_CTL_CLR_LOOP0, `MFP_CTL_CLR_LOOP1
  };

  logic [NUM_PINS-1:0][7:0] func_q;
  logic [NUM_PINS-1:0][7:0] func_act_q;
  logic [7:0]               comb_lo_q;
  logic [7:0]               comb_hi_q;
  logic [15:0]              comb_act_q;
  logic [NUM_PINS-1:0]      sync1_q;
  logic [NUM_PINS-1:0]      sync2_q;
  logic [MFP_NUM_CTL-1:0]   ctl_now;
  logic [MFP_NUM_CTL-1:0]   ctl_q;
  logic                     latch_q;
  logic                     upd_prev_q;
  logic                     core_div_q;
  logic                     sw_update;
  logic                     func_wr;
  logic                     bus_req;
  logic                     bus_wr;
  logic [IW-1:0]            idx;
  logic [31:0]              rd_d;
  logic [NUM_PINS-1:0]      func_sel;
  logic [NUM_PINS-1:0]      stat_lvl;

  // Two-bit mode of one pin from the packed mode field
  function automatic mfp_mode_t pin_mode(input logic [15:0] m,
                                         input int          p);
    pin_mode = m[2*p +: 2];
  endfunction

  // One-hot select of the pin function register an index hits
  function automatic logic [NUM_PINS-1:0] func_hit(input logic [IW-1:0] i);
    func_hit = '0;
    for (int p = 0; p < NUM_PINS; p++) begin
      func_hit[p] = (i == `MFP_IDX_FUNC_FIRST + IW'(p));
    end
  endfunction

  // Combine all control pins carrying one code
  function automatic logic comb_eval(
      input mfp_code_t                c,
      input logic [NUM_PINS-1:0]      lvl,
      input logic [15:0]              m,
      input logic [NUM_PINS-1:0][7:0] f);
    logic      any_and;
    logic      any_or;
    logic      and_v;
    logic      or_v;
    logic      term;
    mfp_mode_t md;
    any_and = 1'b0;
    any_or  = 1'b0;
    and_v   = 1'b1;
    or_v    = 1'b0;
    term    = 1'b0;
    md      = 2'b00;
    for (int p = 0; p < NUM_PINS; p++) begin
      md = pin_mode(m, p);
      if (!f[p][`MFP_FUNC_OE_BIT] &&
          f[p][`MFP_CODE_MSB:0] == c) begin
        term = lvl[p] ^ md[0];
        if (md[1]) begin
          any_or = 1'b1;
          or_v   = or_v | term;
        end else begin
          any_and = 1'b1;
          and_v   = and_v & term;
        end
      end
    end
    // OR group forms one term, then ANDed with the rest
    comb_eval = (any_and | any_or) & and_v &
                (any_or ? or_v : 1'b1);
  endfunction

  // Asserted level of a status code
  function automatic logic stat_sel(input mfp_code_t c,
                                    input logic      clk_div);
    case (c)
      `MFP_ST_ZERO:       stat_sel = 1'b0;
      `MFP_ST_ONE:        stat_sel = 1'b1;
      `MFP_ST_CORE_CLK:   stat_sel = clk_div;
      `MFP_ST_WDOG:       stat_sel = wdog_timeout;
      `MFP_ST_CAL_BUSY:   stat_sel = system_reference_clock_cal_busy;
      `MFP_ST_SYS_LOCK:   stat_sel = system_reference_clock_locked;
      `MFP_ST_SYS_STABLE: stat_sel = system_reference_clock_stable;
      `MFP_ST_BOTH_LOCK:  stat_sel = loop0_locked &
                                     loop1_locked;
      `MFP_ST_LOOP0_LOCK: stat_sel = loop0_locked;
      `MFP_ST_LOOP1_LOCK: stat_sel = loop1_locked;
      `MFP_ST_NV_SAVE:    stat_sel = nv_save_busy;
      `MFP_ST_NV_LOAD:    stat_sel = nv_load_busy;
      `MFP_ST_NV_FAULT:   stat_sel = |nv_fault;
      `MFP_ST_TEMP:       stat_sel = temp_alarm;
      `MFP_ST_IRQ_ALL:    stat_sel = irq_any;
      `MFP_ST_IRQ_COMMON: stat_sel = irq_common;
      `MFP_ST_IRQ_LOOP0:  stat_sel = irq_loop0;
      `MFP_ST_IRQ_LOOP1:  stat_sel = irq_loop1;
      default:            stat_sel = 1'b0;
    endcase
  endfunction

  // Bus decode
  assign bus_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign bus_wr  = bus_req & wb_we_i & wb_sel_i[0];
  assign idx     = wb_adr_i[ADR_W-1:2];
  assign sw_update = bus_wr && idx == `MFP_IDX_UPDATE &&
                     wb_dat_i[`MFP_UPDATE_BIT];
  assign func_sel = func_hit(idx);
  assign func_wr = bus_wr && |func_sel;

  // Pin synchronisers
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      sync1_q <= '0;
      sync2_q <= '0;
    end else if (clk_en) begin
      sync1_q <= pin_in;
      sync2_q <= sync1_q;
    end
  end

  // Shadow registers written by software
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      comb_lo_q <= `MFP_COMB_RST;
      comb_hi_q <= `MFP_COMB_RST;
      for (int p = 0; p < NUM_PINS; p++) begin
        func_q[p] <= `MFP_FUNC_RST;
      end
    end else if (clk_en && bus_wr) begin
      if (idx == `MFP_IDX_COMB_LO) begin
        comb_lo_q <= wb_dat_i[7:0];
      end
      if (idx == `MFP_IDX_COMB_HI) begin
        comb_hi_q <= wb_dat_i[7:0];
      end
      for (int p = 0; p < NUM_PINS; p++) begin
        if (func_sel[p]) begin
          func_q[p] <= wb_dat_i[7:0];
        end
      end
    end
  end

  // Active configuration, loaded only by an update
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      comb_act_q <= {2{`MFP_COMB_RST}};
      for (int p = 0; p < NUM_PINS; p++) begin
        func_act_q[p] <= `MFP_FUNC_RST;
      end
    end else if (clk_en && io_update_o) begin
      comb_act_q <= {comb_hi_q, comb_lo_q};
      func_act_q <= func_q;
    end
  end

  // Latch controls after a function write until update
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      latch_q <= 1'b0;
    end else if (clk_en) begin
      if (func_wr) begin
        latch_q <= 1'b1;
      end else if (io_update_o) begin
        latch_q <= 1'b0;
      end
    end
  end

  // One combiner per control function
  genvar k;
  generate
    for (k = 0; k < MFP_NUM_CTL; k++) begin : g_ctl
      assign ctl_now[k] = comb_eval(CTL_CODES[k], sync2_q,
                                    comb_act_q, func_act_q);
    end
  endgenerate

  // Selected status level of every pin
  genvar s;
  generate
    for (s = 0; s < NUM_PINS; s++) begin : g_stat
      assign stat_lvl[s] = stat_sel(func_act_q[s][`MFP_CODE_MSB:0],
                                    core_div_q);
    end
  endgenerate

  // Control results, frozen while latched
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      ctl_q <= '0;
    end else if (clk_en && !latch_q) begin
      ctl_q <= ctl_now;
    end
  end

  // Control outputs
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      upd_prev_q   <= 1'b0;
      io_update_o  <= 1'b0;
      power_down_o <= 1'b0;
      wdog_clear_o <= 1'b0;
      sync_all_o   <= 1'b0;
      irq_clear_o  <= 4'h0;
    end else if (clk_en) begin
      upd_prev_q   <= ctl_q[0];
      // Pin update acts on its rising edge only
      io_update_o  <= sw_update |
                      (ctl_q[0] & ~upd_prev_q);
      power_down_o <= ctl_q[1];
      wdog_clear_o <= ctl_q[2];
      sync_all_o   <= ctl_q[3];
      irq_clear_o  <= ctl_q[7:4];
    end
  end

  // Half-rate copy of the core clock for status code 0x02
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      core_div_q <= 1'b0;
    end else if (clk_en) begin
      core_div_q <= ~core_div_q;
    end
  end

  // Status drivers
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      pin_out  <= '0;
      pin_oe_b <= '1;
    end else if (clk_en) begin
      for (int p = 0; p < NUM_PINS; p++) begin
        if (func_act_q[p][`MFP_FUNC_OE_BIT]) begin
          case (pin_mode(comb_act_q, p))
            `MFP_MODE_AND: begin
              pin_out[p]  <= stat_lvl[p];
              pin_oe_b[p] <= 1'b0;
            end
            `MFP_MODE_NAND: begin
              pin_out[p]  <= ~stat_lvl[p];
              pin_oe_b[p] <= 1'b0;
            end
            `MFP_MODE_OR: begin
              pin_out[p]  <= 1'b1;
              pin_oe_b[p] <= ~stat_lvl[p];
            end
            default: begin
              pin_out[p]  <= 1'b0;
              pin_oe_b[p] <= ~stat_lvl[p];
            end
          endcase
        end else begin
          pin_out[p]  <= 1'b0;
          pin_oe_b[p] <= 1'b1;
        end
      end
    end
  end

  // Read mux
  always_comb begin
    rd_d = 32'h0000_0000;
    if (idx == `MFP_IDX_COMB_LO) begin
      rd_d[7:0] = comb_lo_q;
    end else if (idx == `MFP_IDX_COMB_HI) begin
      rd_d[7:0] = comb_hi_q;
    end else if (idx == `MFP_IDX_PIN_STATE) begin
      rd_d[NUM_PINS-1:0] = sync2_q;
      rd_d[`MFP_STATE_CTL_LSB +: MFP_NUM_CTL] = ctl_q;
      rd_d[`MFP_STATE_LATCH] = latch_q;
    end
    for (int p = 0; p < NUM_PINS; p++) begin
      if (func_sel[p]) begin
        rd_d[7:0] = func_q[p];
      end
    end
  end

  // Wishbone answer one cycle after the request
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else if (clk_en) begin
      wb_ack_o <= bus_req;
      if (bus_req && !wb_we_i) begin
        wb_dat_o <= rd_d;
      end
    end
  end

endmodule // mfp_pin_map

`default_nettype wire

/* sim/mfp_pin_map_checker.sv */
// Checker of the multifunction pin map, bound to its top ports.
// Assumes one clock domain and classic single-cycle bus requests.
`timescale 1ns/1ps
`default_nettype none

module mfp_pin_map_checker #(
  parameter int NUM_PINS = 7,
  parameter int ADR_W    = 18
) (
  input wire logic                sys_clk,
  input wire logic                rst_b,
  input wire logic                clk_en,
  input wire logic                wb_cyc_i,
  input wire logic                wb_stb_i,
  input wire logic                wb_we_i,
  input wire logic [3:0]          wb_sel_i,
  input wire logic [ADR_W-1:0]    wb_adr_i,
  input wire logic [31:0]         wb_dat_i,
  input wire logic [31:0]         wb_dat_o,
  input wire logic                wb_ack_o,
  input wire logic [NUM_PINS-1:0] pin_out,
  input wire logic [NUM_PINS-1:0] pin_oe_b,
  input wire logic                io_update_o,
  input wire logic                power_down_o,
  input wire logic [3:0]          irq_clear_o
);
  logic [15:0] idx;
  logic        req;
  logic        upd_seen_q;

  assign idx = wb_adr_i[17:2];
  assign req = wb_cyc_i & wb_stb_i & ~wb_ack_o & clk_en;

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) upd_seen_q <= 1'b0;
    else if (io_update_o) upd_seen_q <= 1'b1;
  end

  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_b);

  AST_ACK_ONE: assert property (req |=> wb_ack_o)
    else $error("no ack one cycle after request");
  AST_ACK_PULSE: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held two cycles");
  AST_RD_UNMAPPED: assert property (req && !wb_we_i
    && !(idx inside {[16'h0100:16'h0108], 16'h0110}) |=> wb_dat_o == 32'h0)
    else $error("unmapped or update index read not zero");
  AST_RD_HIGH: assert property (req && !wb_we_i
    && idx inside {[16'h0100:16'h0108]} |=> wb_dat_o[31:8] == 24'h0)
    else $error("config read upper bits not zero");
  AST_UPD_WR: assert property (req && wb_we_i && wb_sel_i[0]
    && wb_dat_i[0] && idx == 16'h000F |-> ##[1:2] io_update_o)
    else $error("update write gave no strobe");
  AST_UPD_PULSE: assert property (io_update_o |=> !io_update_o)
    else $error("update strobe longer than one cycle");
  AST_RST_OUT: assert property ($rose(rst_b) |-> &pin_oe_b
    && pin_out == '0 && !io_update_o && !power_down_o
    && irq_clear_o == 4'h0)
    else $error("outputs not idle after reset");
  AST_OE_HOLD: assert property (!upd_seen_q |-> &pin_oe_b)
    else $error("pin driven before any update");
endmodule // mfp_pin_map_checker

bind mfp_pin_map mfp_pin_map_checker #(.NUM_PINS(NUM_PINS), .ADR_W(ADR_W))
  u_chk (.sys_clk, .rst_b, .clk_en, .wb_cyc_i, .wb_stb_i, .wb_we_i,
  .wb_sel_i, .wb_adr_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .pin_out,
  .pin_oe_b, .io_update_o, .power_down_o, .irq_clear_o);

`default_nettype wire

/* sim/mfp_far_ctrl.sv */
// Far-side controller: drives control levels, resolves each pin wire.
// Assumes released lines settle to the resistor level given in pull.
`timescale 1ns/1ps
`default_nettype none

module mfp_far_ctrl #(
  parameter int N = 7
) (
  input  wire logic [N-1:0] pin_out,
  input  wire logic [N-1:0] pin_oe_b,
  input  wire logic [N-1:0] lvl,
  input  wire logic [N-1:0] drv,
  input  wire logic [N-1:0] pull,
  output logic      [N-1:0] wire_lvl
);
  always_comb begin
    for (int i = 0; i < N; i++) begin
      if (!pin_oe_b[i]) wire_lvl[i] = pin_out[i];
      else if (drv[i]) wire_lvl[i] = lvl[i];
      else wire_lvl[i] = pull[i];
    end
  end
endmodule // mfp_far_ctrl

`default_nettype wire

/* sim/mfp_pin_map_test.sv */
// Testbench of the multifunction pin map: bus master, model, compares.
// Assumes mfp_far_ctrl and the bound checker are compiled with it.
`timescale 1ns/1ps
`default_nettype none

module mfp_pin_map_test;
  logic        sys_clk = 1'b0;
  logic        rst_b   = 1'b0;
  logic        cyc     = 1'b0;
  logic        we      = 1'b0;
  logic        en      = 1'b1;
  logic [3:0]  sel     = 4'hF;
  logic [3:0]  wsel    = 4'hF;
  logic [17:0] adr     = 18'h0;
  logic [31:0] wdat    = 32'h0;
  logic [31:0] dout, rdat;
  logic        ack, upd, pwr, wdc, syn;
  logic [3:0]  clr;
  logic [6:0]  pin_in, pin_out, oe_b, ov, e, eo;
  logic [6:0]  lvl  = 7'h0;
  logic [6:0]  drv  = 7'h0;
  logic [6:0]  pull = 7'h0;
  logic [19:0] st   = 20'h0;
  logic [7:0]  fn [7];
  logic [15:0] md;
  int          n_mismatch = 0;
  int          cmp_count  = 0;

  always #12.5 sys_clk = ~sys_clk;
  assign ov = {clr, syn, wdc, pwr};

  mfp_pin_map DUT (
    .sys_clk(sys_clk), .rst_b(rst_b), .clk_en(en), .wb_cyc_i(cyc),
    .wb_stb_i(cyc), .wb_we_i(we), .wb_sel_i(sel), .wb_adr_i(adr),
    .wb_dat_i(wdat), .wb_dat_o(dout), .wb_ack_o(ack), .pin_in(pin_in),
    .pin_out(pin_out), .pin_oe_b(oe_b), .system_reference_clock_cal_busy(st[4]),
    .system_reference_clock_locked(st[5]), .system_reference_clock_stable(st[6]), .loop0_locked(st[8]),
    .loop1_locked(st[9]), .nv_save_busy(st[10]), .nv_load_busy(st[11]),
    .nv_fault(st[15:14]), .temp_alarm(st[13]), .wdog_timeout(st[3]),
    .irq_any(st[16]), .irq_common(st[17]), .irq_loop0(st[18]),
    .irq_loop1(st[19]), .io_update_o(upd), .power_down_o(pwr),
    .wdog_clear_o(wdc), .sync_all_o(syn), .irq_clear_o(clr));
  mfp_far_ctrl FAR (.pin_out(pin_out), .pin_oe_b(oe_b), .lvl(lvl),
    .drv(drv), .pull(pull), .wire_lvl(pin_in));

  // Status source level per code; status input st[code] where direct
  function automatic logic sx(input logic [6:0] c);
    if (c == 7'h01) return 1'b1;
    if (c == 7'h07) return st[8] & st[9];
    if (c == 7'h0C) return |st[15:14];
    if (c inside {[7'h03:7'h06], [7'h08:7'h0B], 7'h0D, [7'h10:7'h13]})
      return st[c];
    return 1'b0;
  endfunction

  task automatic wb(input logic w, input logic [15:0] ix,
                    input logic [7:0] d);
    int t;
    t = 0;
    @(posedge sys_clk);
    cyc  <= 1'b1;
    we   <= w;
    sel  <= wsel;
    adr  <= {ix, 2'b00};
    wdat <= {24'h0, d};
    do begin
      @(posedge sys_clk);
      t++;
    end while (ack !== 1'b1 && t < 50);
    rdat = dout;
    cyc <= 1'b0;
    if (t >= 50) n_mismatch++;
  endtask

  task automatic chk(input logic [31:0] x, input logic [31:0] g);
    cmp_count++;
    if (g !== x) begin
      n_mismatch++;
      $display("[ERR] %0t exp %h got %h", $time, x, g);
    end
  endtask

  task automatic chkv(input logic [6:0] x, input logic [6:0] g);
    cmp_count++;
    if (g !== x) begin
      n_mismatch++;
      $display("[ERR] %0t exp %h got %h", $time, x, g);
    end
  endtask

  task automatic cfg();
    wb(1'b1, 16'h0100, md[7:0]);
    wb(1'b1, 16'h0101, md[15:8]);
    for (int p = 0; p < 7; p++) wb(1'b1, 16'(16'h0102 + p), fn[p]);
    wb(1'b1, 16'h000F, 8'h01);
    repeat (3) @(posedge sys_clk);
  endtask

  task automatic print_verdict();
    if (n_mismatch == 0 && cmp_count > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge sys_clk);
    n_mismatch++;
    print_verdict();
  end

  initial begin
    int np;
    void'($urandom(32'hBBAE));
    repeat (12) @(posedge sys_clk);
    rst_b <= 1'b1;
    chkv(7'h7F, oe_b);
    for (int i = 0; i < 9; i++) begin
      wb(1'b0, 16'(16'h0100 + i), 8'h00);
      chk(32'h0, rdat);
    end
    wb(1'b1, 16'h0050, 8'hFF);
    wb(1'b0, 16'h0050, 8'h00);
    chk(32'h0, rdat);
    // Write without the low byte lane is ignored
    wsel = 4'hE;
    wb(1'b1, 16'h0100, 8'hFF);
    wsel = 4'hF;
    wb(1'b0, 16'h0100, 8'h00);
    chk(32'h0, rdat);
    // Status pins: every code except 0x02, random driver modes
    for (int r = 0; r < 3; r++) begin
      for (int p = 0; p < 7; p++) begin
        fn[p] = {1'b1, 7'((r * 7 + p) % 20)};
        if (fn[p] == 8'h82) fn[p] = 8'h8E;
      end
      md = 16'($urandom) & 16'h3FFF;
      for (int p = 0; p < 7; p++) pull[p] <= md[2*p];
      cfg();
      wb(1'b0, 16'h0101, 8'h00);
      chk({24'h0, md[15:8]}, rdat);
      wb(1'b0, 16'(16'h0102 + r), 8'h00);
      chk({24'h0, fn[r]}, rdat);
      repeat (4) begin
        st <= 20'($urandom);
        repeat (3) @(posedge sys_clk);
        for (int p = 0; p < 7; p++) begin
          e[p]  = sx(fn[p][6:0]) ^ md[2*p];
          eo[p] = md[2*p+1] & ~sx(fn[p][6:0]);
        end
        chkv(e, pin_in);
        chkv(eo, oe_b);
      end
    end
    // Core clock status: pin toggles every cycle
    fn[0] = 8'h82;
    md = 16'h0000;
    cfg();
    for (int i = 0; i < 4; i++) begin
      e[0] = pin_in[0];
      @(posedge sys_clk);
      chkv({6'h0, ~e[0]}, {6'h0, pin_in[0]});
    end
    // Control pins: one code each, then freeze after a function write
    drv <= 7'h7F;
    fn = '{8'h02, 8'h03, 8'h04, 8'h10, 8'h11, 8'h12, 8'h13};
    for (int r = 0; r < 3; r++) begin
      md = 16'($urandom) & 16'h3FFF;
      cfg();
      repeat (6) begin
        lvl <= 7'($urandom);
        repeat (6) @(posedge sys_clk);
        for (int p = 0; p < 7; p++) e[p] = lvl[p] ^ md[2*p];
        chkv(e, ov);
      end
      wb(1'b1, 16'h0102, fn[0]);
      lvl <= ~lvl;
      repeat (6) @(posedge sys_clk);
      chkv(e, ov);
      wb(1'b0, 16'h0110, 8'h00);
      chk({1'b1, 7'h0, e, 1'b0, 9'h0, lvl}, rdat);
    end
    // Four pins combined onto power down
    fn = '{8'h02, 8'h00, 8'h02, 8'h02, 8'h00, 8'h00, 8'h02};
    md = 16'h2070;
    cfg();
    repeat (12) begin
      lvl <= 7'($urandom);
      repeat (6) @(posedge sys_clk);
      e = {6'h0, (~lvl[2] | lvl[6]) & lvl[0] & ~lvl[3]};
      chkv(e, ov);
    end
    // Clock enable low freezes every control output
    en <= 1'b0;
    lvl <= ~lvl;
    repeat (6) @(posedge sys_clk);
    chkv(e, ov);
    en <= 1'b1;
    // Update strobe from a pin: one pulse per rising level
    fn = '{8'h00, 8'h01, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
    md = 16'h0000;
    lvl <= 7'h00;
    cfg();
    lvl <= 7'h02;
    np = 0;
    repeat (10) begin
      @(posedge sys_clk);
      np += int'(upd);
    end
    chk(32'h1, 32'(np));
    print_verdict();
  end
endmodule // mfp_pin_map_test

`default_nettype wire
